// *** core/picfg_top.sv ***
// Pin input mode and output drive style configuration registers with pin control.
//
// Overview of operation
// - Input mode 0 powers the input buffer down.
// - Input mode 1 enables and routes the input.
// - Input modes sit in bits 5-4, 3-2, 1-0.
// - Drive style 0 drives both levels, no keeper.
// - Drive style 1 drives both levels plus keeper.
// - Address 0x4F holds pins two and one.
// - Address 0x50 holds pins four and three.
// - Address 0x51 holds pins six and five.
// - Address 0x52 holds pins eight and seven.
// - Drive registers live in book 0, page 1.
// - Input mode register at 0x4D, resets zero.
module picfg_top (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [picfg_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [picfg_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [picfg_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [picfg_pkg::NUM_INPUT_PINS-1:0] i_input_pin,
    output logic [picfg_pkg::NUM_INPUT_PINS-1:0] o_input_buf_en,
    output logic [picfg_pkg::NUM_INPUT_PINS-1:0] o_input_routed,
    input wire logic [picfg_pkg::NUM_BIDIR_PINS-1:0] i_bidir_out_value,
    input wire logic [picfg_pkg::NUM_BIDIR_PINS-1:0] i_bidir_out_en,
    input wire logic [picfg_pkg::NUM_BIDIR_PINS-1:0] i_bidir_pin_in,
    output logic [picfg_pkg::NUM_BIDIR_PINS-1:0] o_bidir_pin_out,
    output logic [picfg_pkg::NUM_BIDIR_PINS-1:0] o_bidir_pin_oe_n,
    output logic [picfg_pkg::NUM_BIDIR_PINS-1:0] o_bidir_keep_en
);
    import picfg_pkg::*;

    picfg_top_state_t state_reg;
    picfg_top_state_t state_next;

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic in_cfg_page(input logic [DATA_W-1:0] book,
                                         input logic [DATA_W-1:0] page);
        return (book == CFG_BOOK) && (page == CFG_PAGE);
    endfunction

    // Maps an access address to a drive register index; -1 when not one.
    function automatic int drive_index(input logic [ADDR_W-1:0] addr);
        case (addr)
            ADDR_PINS_ONE_TWO_DRIVE_STYLE: drive_index = 0;
            ADDR_PINS_THREE_FOUR_DRIVE_STYLE: drive_index = 1;
            ADDR_PINS_FIVE_SIX_DRIVE_STYLE: drive_index = 2;
            ADDR_PINS_SEVEN_EIGHT_DRIVE_STYLE: drive_index = 3;
            default: drive_index = -1;
        endcase
    endfunction

    // Even pins (numbered from zero) use the lower field, odd pins the upper.
    function automatic logic [DRIVE_STYLE_W-1:0] drive_style_of(
            input logic [NUM_DRIVE_REGS-1:0][DATA_W-1:0] drive, input int pin);
        logic [DATA_W-1:0] r;
        r = drive[pin / 2];
        if (pin % 2 == 1) begin
            drive_style_of = r[DRIVE_UPPER_LSB +: DRIVE_STYLE_W];
        end else begin
            drive_style_of = r[DRIVE_LOWER_LSB +: DRIVE_STYLE_W];
        end
    endfunction

    function automatic logic [INPUT_MODE_W-1:0] input_mode_of(
            input logic [DATA_W-1:0] modes, input int pin);
        logic [INPUT_MODE_W-1:0] m;
        case (pin)
            0: m = modes[INPUT_PIN_ONE_MODE_LSB +: INPUT_MODE_W];
            1: m = modes[INPUT_PIN_TWO_MODE_LSB +: INPUT_MODE_W];
            default: m = modes[INPUT_PIN_THREE_MODE_LSB +: INPUT_MODE_W];
        endcase
        return m;
    endfunction

    function automatic logic [DATA_W-1:0] read_value(input picfg_top_state_t s,
                                                     input logic [ADDR_W-1:0] addr);
        int idx;
        idx = drive_index(addr);
        if (addr == ADDR_PAGE_SEL) begin
            read_value = s.page;
        end else if (addr == ADDR_BOOK_SEL) begin
            read_value = s.book;
        end else if (!in_cfg_page(s.book, s.page)) begin
            read_value = 8'h00;
        end else if (addr == ADDR_INPUT_PIN_MODES) begin
            read_value = s.input_pin_modes;
        end else if (idx >= 0) begin
            read_value = s.drive[idx];
        end else begin
            read_value = 8'h00;
        end
    endfunction

    // =========================================================================
    // Register file and input pin control
    // =========================================================================
    always_comb begin
        int idx;
        logic sel;
        idx = drive_index(i_reg_addr);
        sel = in_cfg_page(state_reg.book, state_reg.page);
        state_next = state_reg;

        // A read in the same cycle as a write returns the value before the write.
        state_next.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            state_next.rdata = read_value(state_reg, i_reg_addr);
        end else begin
            state_next.rdata = 8'h00;
        end

        if (i_reg_wr) begin
            if (i_reg_addr == ADDR_PAGE_SEL) begin
                state_next.page = i_reg_wdata;
            end else if (i_reg_addr == ADDR_BOOK_SEL) begin
                state_next.book = i_reg_wdata;
            // Only reachable in the configuration page.
            end else if (sel && i_reg_addr == ADDR_INPUT_PIN_MODES) begin
                // Full byte kept, reserved bits too.
                state_next.input_pin_modes = i_reg_wdata;
            end else if (sel && idx >= 0) begin
                state_next.drive[idx] = i_reg_wdata;
            end
        end

        for (int k = 0; k < NUM_INPUT_PINS; k++) begin
            // Disabled or reserved modes keep the buffer off.
            // Mode 1 enables and routes the pin.
            if (input_mode_of(state_reg.input_pin_modes, k) == MODE_INPUT) begin
                state_next.in_buf_en[k] = 1'b1;
                state_next.in_routed[k] = i_input_pin[k];
            end else begin
                state_next.in_buf_en[k] = 1'b0;
                state_next.in_routed[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_reg.page <= RESET_PAGE;
            state_reg.book <= RESET_BOOK;
            // Input mode fields reset to zero.
            state_reg.input_pin_modes <= RESET_INPUT_PIN_MODES;
            state_reg.drive <= {NUM_DRIVE_REGS{RESET_DRIVE_STYLE}};
            state_reg.rdata <= 8'h00;
            state_reg.rvalid <= 1'b0;
            state_reg.in_buf_en <= '0;
            state_reg.in_routed <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_reg_rdata = state_reg.rdata;
    assign o_reg_rvalid = state_reg.rvalid;
    assign o_input_buf_en = state_reg.in_buf_en;
    assign o_input_routed = state_reg.in_routed;

    // =========================================================================
    // Bidirectional pin stages
    // =========================================================================
    for (genvar p = 0; p < NUM_BIDIR_PINS; p++) begin : g_pad
        // Pin pairs map onto their registers.
        // Pins five and six from the third register.
        // Pins seven and eight from the fourth register.
        picfg_pad u_pad (
            .i_ref_clk(i_ref_clk),
            .i_reset_n(i_reset_n),
            .i_style(drive_style_of(state_reg.drive, p)),
            .i_out_value(i_bidir_out_value[p]),
            .i_out_en(i_bidir_out_en[p]),
            .i_pin_in(i_bidir_pin_in[p]),
            .o_pin_out(o_bidir_pin_out[p]),
            .o_pin_oe_n(o_bidir_pin_oe_n[p]),
            .o_keep_en(o_bidir_keep_en[p])
        );
    end

    // =========================================================================
    // Checks
    // =========================================================================
    default clocking top_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    logic cfg_sel;
    assign cfg_sel = in_cfg_page(state_reg.book, state_reg.page);

    reset_clear_a: assert property (disable iff (1'b0)
        !i_reset_n |=> state_reg.drive == '0 && state_reg.input_pin_modes == 8'h00)
        else $error("configuration not cleared by reset");
    drive_write_a: assert property (i_reg_wr && cfg_sel && i_reg_addr == 8'h50
        |=> state_reg.drive[1] == $past(i_reg_wdata))
        else $error("write to pins three and four not stored");
    off_page_a: assert property (i_reg_wr && !cfg_sel && i_reg_addr == 8'h4F
        |=> $stable(state_reg.drive[0]))
        else $error("drive register written outside its page");
    mode_readback_a: assert property (i_reg_rd && !i_reg_wr && cfg_sel
        && i_reg_addr == 8'h4D |=> o_reg_rvalid && o_reg_rdata == state_reg.input_pin_modes)
        else $error("input mode readback mismatch");
    // The read must name the same register, or an unrelated read would trip this.
    drive_readback_a: assert property (i_reg_wr && cfg_sel && i_reg_addr == 8'h52
        ##1 i_reg_rd && !i_reg_wr && i_reg_addr == 8'h52
        |=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("pins seven and eight readback mismatch");
    buf_enable_a: assert property (state_reg.input_pin_modes[5:4] == 2'h1
        |=> o_input_buf_en[2] && o_input_routed[2] == $past(i_input_pin[2]))
        else $error("input pin three not enabled in input mode");
    buf_off_a: assert property (state_reg.input_pin_modes[1:0] != 2'h1
        |=> !o_input_buf_en[0] && !o_input_routed[0])
        else $error("input pin one active while disabled");
    keeper_map_a: assert property (state_reg.drive[0][6:4] == 3'h1 && !i_bidir_out_en[1]
        |=> o_bidir_keep_en[1])
        else $error("pin two keeper not following its field");
    style_map_a: assert property (state_reg.drive[2][2:0] == 3'h0 |=> !o_bidir_keep_en[4])
        else $error("pin five keeper on in push-pull style");

    page_select_c: cover property (i_reg_wr && i_reg_addr == ADDR_PAGE_SEL
        && i_reg_wdata == CFG_PAGE ##1 cfg_sel);
    write_read_c: cover property (i_reg_wr && cfg_sel && i_reg_addr == ADDR_INPUT_PIN_MODES
        ##1 i_reg_rd);
    input_on_c: cover property (o_input_buf_en[0] && o_input_routed[0]);

endmodule

// *** core/picfg_pkg.sv ***
// Constants and types shared by the pin input and drive configuration block.
package picfg_pkg;

    // =========================================================================
    // Register port widths and pin counts
    // =========================================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_INPUT_PINS = 3;
    localparam int NUM_BIDIR_PINS = 8;
    localparam int NUM_DRIVE_REGS = 4;
    localparam int INPUT_MODE_W = 2;
    localparam int DRIVE_STYLE_W = 3;

    // =========================================================================
    // Register offsets within the paged space
    // =========================================================================
    localparam logic [ADDR_W-1:0] ADDR_PAGE_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BOOK_SEL = 8'h7F;
    localparam logic [ADDR_W-1:0] ADDR_INPUT_PIN_MODES = 8'h4D;
    localparam logic [ADDR_W-1:0] ADDR_PINS_ONE_TWO_DRIVE_STYLE = 8'h4F;
    localparam logic [ADDR_W-1:0] ADDR_PINS_THREE_FOUR_DRIVE_STYLE = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_PINS_FIVE_SIX_DRIVE_STYLE = 8'h51;
    localparam logic [ADDR_W-1:0] ADDR_PINS_SEVEN_EIGHT_DRIVE_STYLE = 8'h52;

    // The configuration registers live only in this book and page.
    localparam logic [DATA_W-1:0] CFG_BOOK = 8'h00;
    localparam logic [DATA_W-1:0] CFG_PAGE = 8'h01;

    // =========================================================================
    // Field positions, encodings and reset values
    // =========================================================================
    localparam int INPUT_PIN_ONE_MODE_LSB = 0;
    localparam int INPUT_PIN_TWO_MODE_LSB = 2;
    localparam int INPUT_PIN_THREE_MODE_LSB = 4;
    localparam int DRIVE_LOWER_LSB = 0;
    localparam int DRIVE_UPPER_LSB = 4;

    localparam logic [INPUT_MODE_W-1:0] MODE_DISABLED = 2'h0;
    localparam logic [INPUT_MODE_W-1:0] MODE_INPUT = 2'h1;
    localparam logic [DRIVE_STYLE_W-1:0] DRIVE_PUSH_PULL = 3'h0;
    localparam logic [DRIVE_STYLE_W-1:0] DRIVE_PUSH_PULL_KEEPER = 3'h1;

    localparam logic [DATA_W-1:0] RESET_PAGE = 8'h00;
    localparam logic [DATA_W-1:0] RESET_BOOK = 8'h00;
    localparam logic [DATA_W-1:0] RESET_INPUT_PIN_MODES = 8'h00;
    localparam logic [DATA_W-1:0] RESET_DRIVE_STYLE = 8'h00;

    // =========================================================================
    // State records
    // =========================================================================
    typedef struct packed {
        logic [DATA_W-1:0] page;
        logic [DATA_W-1:0] book;
        logic [DATA_W-1:0] input_pin_modes;
        logic [NUM_DRIVE_REGS-1:0][DATA_W-1:0] drive;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic [NUM_INPUT_PINS-1:0] in_buf_en;
        logic [NUM_INPUT_PINS-1:0] in_routed;
    } picfg_top_state_t;

    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
        logic keep_en;
        logic held;
    } picfg_pad_state_t;

endpackage

// *** core/picfg_pad.sv ***
// Output stage of one bidirectional pin with optional bus keeper.
module picfg_pad (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [picfg_pkg::DRIVE_STYLE_W-1:0] i_style,
    input wire logic i_out_value,
    input wire logic i_out_en,
    input wire logic i_pin_in,
    output logic o_pin_out,
    output logic o_pin_oe_n,
    output logic o_keep_en
);
    import picfg_pkg::*;

    picfg_pad_state_t state_reg;
    picfg_pad_state_t state_next;

    // =========================================================================
    // Drive and keeper
    // =========================================================================
    always_comb begin
        state_next = state_reg;
        if (i_out_en) begin
            state_next.pin_out = i_out_value;
            state_next.pin_oe_n = 1'b0;
            state_next.keep_en = 1'b0;
            state_next.held = i_out_value;
        end else if (i_style == DRIVE_PUSH_PULL_KEEPER) begin
            // Weak keeper holds the last level.
            // The keeper follows the wire so an outside driver can still win.
            state_next.pin_out = state_reg.held;
            state_next.pin_oe_n = 1'b1;
            state_next.keep_en = 1'b1;
            state_next.held = i_pin_in;
        end else begin
            // Reserved styles behave as plain push-pull, so the wire floats.
            state_next.pin_out = 1'b0;
            state_next.pin_oe_n = 1'b1;
            state_next.keep_en = 1'b0;
            state_next.held = i_pin_in;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_reg <= '0;
            state_reg.pin_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_pin_out = state_reg.pin_out;
    assign o_pin_oe_n = state_reg.pin_oe_n;
    assign o_keep_en = state_reg.keep_en;

    // =========================================================================
    // Checks
    // =========================================================================
    default clocking pad_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    pad_drive_a: assert property (i_out_en
        |=> !o_pin_oe_n && o_pin_out == $past(i_out_value))
        else $error("pad not driving the requested level");
    pad_keeper_a: assert property (!i_out_en && i_style == DRIVE_PUSH_PULL_KEEPER
        |=> o_keep_en && o_pin_oe_n)
        else $error("keeper not enabled while released");
    pad_no_keeper_a: assert property (i_style == DRIVE_PUSH_PULL |=> !o_keep_en)
        else $error("keeper enabled in push-pull style");
    pad_keeper_c: cover property (i_out_en ##1 !i_out_en && i_style == DRIVE_PUSH_PULL_KEEPER
        ##1 o_keep_en);

endmodule

// *** test/tb_top.sv ***
// Self-checking testbench for the pin input and drive configuration block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import picfg_pkg::*;

    // =========================================================================
    // Stimulus signals and design instance
    // =========================================================================
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [ADDR_W-1:0] i_reg_addr = 8'h00;
    logic [DATA_W-1:0] i_reg_wdata = 8'h00;
    logic [DATA_W-1:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic [NUM_INPUT_PINS-1:0] i_input_pin = 3'h0;
    logic [NUM_INPUT_PINS-1:0] o_input_buf_en;
    logic [NUM_INPUT_PINS-1:0] o_input_routed;
    logic [NUM_BIDIR_PINS-1:0] i_bidir_out_value = 8'h00;
    logic [NUM_BIDIR_PINS-1:0] i_bidir_out_en = 8'h00;
    logic [NUM_BIDIR_PINS-1:0] i_bidir_pin_in = 8'h00;
    logic [NUM_BIDIR_PINS-1:0] o_bidir_pin_out;
    logic [NUM_BIDIR_PINS-1:0] o_bidir_pin_oe_n;
    logic [NUM_BIDIR_PINS-1:0] o_bidir_keep_en;
    int miscompares = 0;
    int samples_checked = 0;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } picfg_row_t;

    // Unmapped 0x55 must swallow the write and read back zero.
    // Legal field codes only; reserved bits set freely.
    picfg_row_t rows[6] = '{
        '{8'h4D, 8'hC4, 8'hC4}, '{8'h4F, 8'h19, 8'h19}, '{8'h50, 8'h99, 8'h99},
        '{8'h51, 8'h88, 8'h88}, '{8'h52, 8'h91, 8'h91}, '{8'h55, 8'hFF, 8'h00}};

    always #2.5 i_ref_clk = ~i_ref_clk;

    picfg_top picfg_top_inst (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid),
        .i_input_pin(i_input_pin),
        .o_input_buf_en(o_input_buf_en),
        .o_input_routed(o_input_routed),
        .i_bidir_out_value(i_bidir_out_value),
        .i_bidir_out_en(i_bidir_out_en),
        .i_bidir_pin_in(i_bidir_pin_in),
        .o_bidir_pin_out(o_bidir_pin_out),
        .o_bidir_pin_oe_n(o_bidir_pin_oe_n),
        .o_bidir_keep_en(o_bidir_keep_en)
    );

    // =========================================================================
    // Bus tasks and comparisons
    // =========================================================================
    task automatic finish_test();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t register read got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t pin output got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_ref_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = addr;
        i_reg_wdata = data;
        @(negedge i_ref_clk);
        i_reg_wr = 1'b0;
    endtask

    // The answer stands for one cycle only, so it is taken at the next falling edge.
    task automatic read_expect(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge i_ref_clk);
        i_reg_rd = 1'b1;
        i_reg_addr = addr;
        @(negedge i_ref_clk);
        i_reg_rd = 1'b0;
        check_reg({7'h00, o_reg_rvalid}, 8'h01);
        check_reg(o_reg_rdata, exp);
    endtask

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        // The sequence needs under two thousand cycles; five thousand leaves margin.
        #(5000 * 5);
        miscompares++;
        finish_test();
    end

    initial begin
        logic [7:0] wd;
        logic [2:0] exp3;
        idle(6);
        i_reset_n = 1'b1;
        check_pin(o_bidir_pin_oe_n, 8'hFF);
        check_pin(o_bidir_keep_en | {5'h00, o_input_buf_en}, 8'h00);
        // Page still 0: the configuration space refuses the access.
        reg_write(ADDR_PINS_ONE_TWO_DRIVE_STYLE, 8'h11);
        read_expect(ADDR_PINS_ONE_TWO_DRIVE_STYLE, 8'h00);
        reg_write(ADDR_PAGE_SEL, CFG_PAGE);
        for (int r = 0; r < 4; r++) begin
            read_expect(ADDR_PINS_ONE_TWO_DRIVE_STYLE + 8'(r), 8'h00);
        end
        read_expect(ADDR_INPUT_PIN_MODES, 8'h00);
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            read_expect(rows[i].addr, rows[i].rexp);
        end
        // Write then read in the very next cycle: the read sees the fresh byte.
        @(negedge i_ref_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = ADDR_PINS_SEVEN_EIGHT_DRIVE_STYLE;
        i_reg_wdata = 8'h90;
        @(negedge i_ref_clk);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b1;
        @(negedge i_ref_clk);
        i_reg_rd = 1'b0;
        check_reg({7'h00, o_reg_rvalid}, 8'h01);
        check_reg(o_reg_rdata, 8'h90);
        // Wrong book hides the registers even with the right page.
        reg_write(ADDR_BOOK_SEL, 8'h01);
        read_expect(ADDR_PINS_THREE_FOUR_DRIVE_STYLE, 8'h00);
        reg_write(ADDR_BOOK_SEL, CFG_BOOK);
        read_expect(ADDR_PINS_THREE_FOUR_DRIVE_STYLE, 8'h99);
        // Read and write in one cycle: the read sees the old contents.
        @(negedge i_ref_clk);
        i_reg_wr = 1'b1;
        i_reg_rd = 1'b1;
        i_reg_addr = ADDR_PINS_THREE_FOUR_DRIVE_STYLE;
        i_reg_wdata = 8'h10;
        @(negedge i_ref_clk);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        check_reg(o_reg_rdata, 8'h99);
        read_expect(ADDR_PINS_THREE_FOUR_DRIVE_STYLE, 8'h10);
        // Both legal mode codes on every input pin, reserved bits set.
        for (int m = 0; m < 4; m++) begin
            i_input_pin = 3'(5 + m);
            wd = {2'b11, 1'b0, 1'(m), 1'b0, 1'(m >> 1), 1'b0, 1'(~m)};
            reg_write(ADDR_INPUT_PIN_MODES, wd);
            idle(2);
            exp3 = 3'h0;
            for (int k = 0; k < 3; k++) begin
                exp3[k] = (wd[2 * k +: 2] == 2'h1);
            end
            check_pin({5'h00, o_input_buf_en}, {5'h00, exp3});
            check_pin({5'h00, o_input_routed}, {5'h00, exp3 & i_input_pin});
        end
        // Keeper on one pin at a time, reserved bits set everywhere.
        i_bidir_pin_in = 8'hA5;
        for (int p = 0; p < 8; p++) begin
            for (int r = 0; r < 4; r++) begin
                wd = 8'h88;
                if (r == p / 2) begin
                    wd = wd | (8'h01 << (4 * (p % 2)));
                end
                reg_write(ADDR_PINS_ONE_TWO_DRIVE_STYLE + 8'(r), wd);
            end
            idle(3);
            check_pin(o_bidir_keep_en, 8'h01 << p);
            check_pin(o_bidir_pin_out, (8'h01 << p) & 8'hA5);
            check_pin(o_bidir_pin_oe_n, 8'hFF);
        end
        // Strong drive with keeper armed, then release: the level is held.
        for (int r = 0; r < 4; r++) begin
            reg_write(ADDR_PINS_ONE_TWO_DRIVE_STYLE + 8'(r), 8'h11);
        end
        i_bidir_out_value = 8'h3C;
        i_bidir_pin_in = 8'h3C;
        i_bidir_out_en = 8'hFF;
        idle(3);
        check_pin(o_bidir_pin_oe_n, 8'h00);
        check_pin(o_bidir_pin_out, 8'h3C);
        check_pin(o_bidir_keep_en, 8'h00);
        i_bidir_out_en = 8'h00;
        idle(3);
        check_pin(o_bidir_keep_en, 8'hFF);
        check_pin(o_bidir_pin_out, 8'h3C);
        // Plain push-pull on pin one, keeper on pin two, reserved bit set.
        for (int r = 0; r < 4; r++) begin
            reg_write(ADDR_PINS_ONE_TWO_DRIVE_STYLE + 8'(r), 8'h00);
        end
        reg_write(ADDR_PINS_ONE_TWO_DRIVE_STYLE, 8'h18);
        i_bidir_pin_in = 8'h3E;
        i_bidir_out_en = 8'hF0;
        idle(3);
        check_pin(o_bidir_keep_en, 8'h02);
        check_pin(o_bidir_pin_oe_n, 8'h0F);
        check_pin(o_bidir_pin_out, 8'h32);
        // Reset in mid-run clears every register and the page select.
        @(negedge i_ref_clk);
        i_reset_n = 1'b0;
        idle(2);
        i_reset_n = 1'b1;
        i_bidir_out_en = 8'h00;
        check_pin(o_bidir_pin_oe_n, 8'hFF);
        read_expect(ADDR_INPUT_PIN_MODES, 8'h00);
        reg_write(ADDR_PAGE_SEL, CFG_PAGE);
        read_expect(ADDR_PINS_ONE_TWO_DRIVE_STYLE, 8'h00);
        read_expect(ADDR_INPUT_PIN_MODES, 8'h00);
        finish_test();
    end
endmodule
